// file: hdl/ube_buffer_empty_irq.sv
// per-pipe buffer-empty interrupt status, enable gating and stall forcing
`timescale 1ns/100ps
`default_nettype none
module ube_buffer_empty_irq
    import ube_pkg::*;
#(
    parameter int PIPES = UBE_PIPES,
    parameter int MPS_W = UBE_MPS_W
)
(
    // clock and reset
    input  wire logic                   ref_clk_in,
    input  wire logic                   srst_in,
    // pipe configuration
    input  wire logic [PIPES-1:0]       pipe_dir_tx_in,
    input  wire logic [2*PIPES-1:0]     pipe_response_select_in,
    input  wire logic [PIPES-1:0]       dbl_buf_in,
    input  wire logic                   func_mode_in,
    // transmit events
    input  wire logic [PIPES-1:0]       tx_done_in,
    input  wire logic [PIPES-1:0]       fifo_empty_in,
    input  wire logic [PIPES-1:0]       cpu_wr_started_in,
    input  wire logic [PIPES-1:0]       auto_clear_mode_in,
    input  wire logic [PIPES-1:0]       fifo_clear_bit_in,
    input  wire logic                   status_stage_in,
    // receive events, pipe chosen by index
    input  wire logic                   rx_done_in,
    input  wire logic [3:0]             rx_pipe_in,
    input  wire logic [MPS_W-1:0]       rx_len_in,
    input  wire logic [PIPES*MPS_W-1:0] max_pkt_in,
    input  wire logic                   rx_crc_err_in,
    input  wire logic                   rx_stuff_err_in,
    input  wire logic                   setup_in,
    // software access to the status and enable registers
    input  wire logic                   sts_wr_in,
    input  wire logic [PIPES-1:0]       sts_wdata_in,
    input  wire logic [PIPES-1:0]       empty_enable_register_in,
    // results
    output logic [PIPES-1:0]            empty_status_register_out,
    output logic                        buffer_empty_interrupt_out,
    output logic [PIPES-1:0]            buffer_ready_req_out,
    output logic [PIPES-1:0]            stall_force_out,
    output logic                        rx_discard_out,
    output logic                        send_stall_hs_out,
    output logic                        send_no_hs_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // flags and summary persist; the other registers are one-cycle
    // strobes that fall back to zero on their own
    logic [PIPES-1:0] flag_q;       // sticky per-pipe flags
    logic [PIPES-1:0] flag_d;       // next flags
    logic             summ_q;       // summary interrupt bit
    logic [PIPES-1:0] stall_q;      // stall force pulses
    logic             disc_q;       // discard pulse
    logic             stall_hs_q;   // stall handshake request
    logic             no_hs_q;      // silent response request

    // ------------------------------------------------------------
    // per-pipe qualification
    // ------------------------------------------------------------
    // each pipe gets its own qualifier; the transmit and receive
    // suppression cases live there, so this level only sees clean
    // requests. only one receive event arrives per cycle, so the
    // index decode picks at most one pipe and the stall strobe
    // can never name two pipes at once.
    logic [PIPES-1:0] tx_req;       // transmit empty requests
    logic [PIPES-1:0] rx_req;       // oversize requests
    logic [PIPES-1:0] resp_buf;     // pipe answers by buffer state
    logic [PIPES-1:0] set_ev;       // flag set events

    // receive events carry a 4-bit pipe index, which bounds the
    // pipe count of this build at 16; larger builds need a wider
    // index port
    genvar g;
    generate
        for (g = 0; g < PIPES; g++)
        begin : g_pipe
            wire rx_sel;   // receive event aimed at this pipe
            assign rx_sel = rx_done_in & (rx_pipe_in == 4'(g));
            ube_pipe_qual #(
                .MPS_W (MPS_W)
            ) u_qual (
                .tx_is_in          (pipe_dir_tx_in[g]),
                .tx_done_in        (tx_done_in[g]),
                .fifo_empty_in     (fifo_empty_in[g]),
                .dbl_buf_in        (dbl_buf_in[g]),
                .cpu_wr_started_in (cpu_wr_started_in[g]),
                .sw_clear_in       (auto_clear_mode_in[g] | fifo_clear_bit_in[g]),
                .func_mode_in      (func_mode_in),
                .status_stage_in   (status_stage_in),
                .rx_done_in        (rx_sel),
                .rx_len_in         (rx_len_in),
                .max_pkt_in        (max_pkt_in[g*MPS_W +: MPS_W]),
                .rx_crc_err_in     (rx_crc_err_in),
                .rx_stuff_err_in   (rx_stuff_err_in),
                .setup_in          (setup_in),
                .tx_req_out        (tx_req[g]),
                .rx_req_out        (rx_req[g])
            );
            // only pipes in buffer response mode record the event
            assign resp_buf[g] = pipe_response_select_in[2*g +: 2] == UBE_RESP_BUF;
            assign set_ev[g]   = resp_buf[g] & (tx_req[g] | rx_req[g]);
            // single buffer ready fires together, control pipe excluded
            // double-buffered pipes leave the ready path to the plane logic
            if (g == UBE_CTRL_PIPE)
            begin : g_ctrl
                assign buffer_ready_req_out[g] = 1'b0;
            end
            else
            begin : g_data
                assign buffer_ready_req_out[g] = tx_req[g] & ~dbl_buf_in[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // flag update: write zero clears, one ignored, set wins
    // ------------------------------------------------------------
    // a zero written to a bit clears it and a one leaves it alone.
    // when hardware sets a bit in the same cycle that software clears
    // it, the set wins, so no event is ever lost to a late clear.
    // the summary is taken from the next flags, so it rises together
    // with the flag that caused it rather than a cycle later, and it
    // follows enable changes one cycle after they are made.
    wire [PIPES-1:0] clr_mask;      // bits software clears
    wire             any_rx;        // oversize seen on some buffer-answered pipe
    wire             summ_d;        // summary next value

    assign clr_mask = sts_wr_in ? ~sts_wdata_in : '0;
    assign flag_d   = (flag_q & ~clr_mask) | set_ev;
    assign summ_d   = |(flag_d & empty_enable_register_in);
    // oversize seen on any buffer-answered pipe
    assign any_rx   = |(rx_req & resp_buf);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // four short processes, one per kind of result, each with the
    // synchronous reset taking priority over any event

    // sticky per-pipe flags; a set in the clearing cycle survives
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            flag_q <= {PIPES{UBE_FLAG_RST}};             // all pipes quiet
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // summary bit, built from the next flags so it rises with them
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            summ_q <= 1'b0;                              // no interrupt pending
        end
        else
        begin
            summ_q <= summ_d;
        end
    end

    // per-pipe stall force, one cycle, for the pipe configuration logic
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            stall_q <= '0;                               // no stall forced
        end
        else
        begin
            stall_q <= rx_req & resp_buf;
        end
    end

    // discard and handshake choice, one-cycle strobes to the packet engine
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            disc_q     <= 1'b0;                          // keep the data
            stall_hs_q <= 1'b0;                          // no stall answer
            no_hs_q    <= 1'b0;                          // no silent answer
        end
        else
        begin
            disc_q     <= any_rx;
            stall_hs_q <= any_rx & func_mode_in;
            no_hs_q    <= any_rx & ~func_mode_in;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every result except the ready request leaves straight from a
    // register, so those pins never glitch; the ready request is a
    // handshake and must land in the same cycle as the event
    assign empty_status_register_out  = flag_q;
    assign buffer_empty_interrupt_out = summ_q;
    assign stall_force_out            = stall_q;
    assign rx_discard_out             = disc_q;
    assign send_stall_hs_out          = stall_hs_q;
    assign send_no_hs_out             = no_hs_q;
endmodule : ube_buffer_empty_irq
`default_nettype wire

// file: hdl/ube_pipe_qual.sv
// per-pipe qualification of buffer-empty request conditions
`timescale 1ns/100ps
`default_nettype none
module ube_pipe_qual
    import ube_pkg::*;
#(
    parameter int MPS_W = UBE_MPS_W
)
(
    // transmit side
    input  wire logic             tx_is_in,
    input  wire logic             tx_done_in,
    input  wire logic             fifo_empty_in,
    input  wire logic             dbl_buf_in,
    input  wire logic             cpu_wr_started_in,
    input  wire logic             sw_clear_in,
    input  wire logic             func_mode_in,
    input  wire logic             status_stage_in,
    // receive side
    input  wire logic             rx_done_in,
    input  wire logic [MPS_W-1:0] rx_len_in,
    input  wire logic [MPS_W-1:0] max_pkt_in,
    input  wire logic             rx_crc_err_in,
    input  wire logic             rx_stuff_err_in,
    input  wire logic             setup_in,
    // results
    output logic                  tx_req_out,
    output logic                  rx_req_out
);
    // ------------------------------------------------------------
    // condition decode
    // ------------------------------------------------------------
    wire tx_base;       // empty at end of send, zero length included
    wire tx_block;      // suppressing cases
    wire rx_bad;        // corrupted packet
    wire rx_big;        // longer than maximum packet size

    assign tx_base  = tx_is_in & tx_done_in & fifo_empty_in;
    assign tx_block = (dbl_buf_in & cpu_wr_started_in)
                    | sw_clear_in
                    | (func_mode_in & status_stage_in);
    assign rx_bad   = rx_crc_err_in | rx_stuff_err_in;
    assign rx_big   = rx_len_in > max_pkt_in;
    // setup transactions block both directions
    assign tx_req_out = tx_base & ~tx_block & ~setup_in;
    assign rx_req_out = ~tx_is_in & rx_done_in & rx_big & ~rx_bad & ~setup_in;
endmodule : ube_pipe_qual
`default_nettype wire

// file: hdl/ube_pkg.sv
// package of constants for the per-pipe buffer-empty interrupt logic
package ube_pkg;
    // ------------------------------------------------------------
    // pipe response selection encodings
    // ------------------------------------------------------------
    localparam logic [1:0] UBE_RESP_NAK   = 2'h0;  // no data accepted
    localparam logic [1:0] UBE_RESP_BUF   = 2'h1;  // answer by buffer state
    localparam logic [1:0] UBE_RESP_STALL = 2'h3;  // stall, code 11

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int         UBE_PIPES      = 10;    // default pipe count
    localparam int         UBE_MPS_W      = 11;    // packet size width
    localparam logic       UBE_FLAG_RST   = 1'b0;  // flags cleared at reset
    localparam int         UBE_CTRL_PIPE  = 0;     // default control pipe index

    // ------------------------------------------------------------
    // per-pipe event kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        UBE_EV_NONE,
        UBE_EV_TX_EMPTY,
        UBE_EV_RX_OVERSIZE
    } ube_event_e;
endpackage : ube_pkg

// file: verification/tb.sv
// self-checking bench for the buffer-empty interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ube_pkg::*;
    localparam int P = UBE_PIPES;
    localparam logic [10:0] M = 11'h040; // max packet size, every pipe
    localparam logic [P-1:0] DB = 10'h004; // double-buffered pipes
    logic ref_clk_in = 1'b0, srst_in = 1'b1, fm = 1'b0, ss = 1'b0, sw = 1'b0, chk = 1'b0, chr = 1'b0;
    logic [P-1:0] emp = '0, cw = '0, ac = '0, bc = '0, wd = '0, en = 10'h3EF, fl = '0;
    wire logic [P-1:0] txd, st, brq, sf;
    wire logic rxd, crc, stf, stp, irq, dis, shs, nhs;
    wire logic [3:0] rxp;
    wire logic [10:0] rxl;
    logic [23:0] q[$]; // expected results, oldest first
    logic [P-1:0] qr[$]; // expected ready requests, oldest first
    logic [P-1:0] rq = '0; // ready request expected for the next event
    int failures = 0, checks = 0, cyc = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    ube_peer_model i_ube_peer_model (.tx_done_out(txd), .rx_done_out(rxd), .crc_err_out(crc),
        .stuff_err_out(stf), .setup_out(stp), .rx_pipe_out(rxp), .rx_len_out(rxl));
    // pipes 0-4 transmit, pipe 2 double buffered, pipe 9 not buffer-answered
    ube_buffer_empty_irq i_ube_buffer_empty_irq (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .pipe_dir_tx_in(10'h01F), .pipe_response_select_in({2'h0, {9{UBE_RESP_BUF}}}), .dbl_buf_in(DB),
        .func_mode_in(fm), .tx_done_in(txd), .fifo_empty_in(emp), .cpu_wr_started_in(cw),
        .auto_clear_mode_in(ac), .fifo_clear_bit_in(bc), .status_stage_in(ss), .rx_done_in(rxd),
        .rx_pipe_in(rxp), .rx_len_in(rxl), .max_pkt_in({P{M}}), .rx_crc_err_in(crc), .rx_stuff_err_in(stf),
        .setup_in(stp), .sts_wr_in(sw), .sts_wdata_in(wd), .empty_enable_register_in(en),
        .empty_status_register_out(st), .buffer_empty_interrupt_out(irq), .buffer_ready_req_out(brq),
        .stall_force_out(sf), .rx_discard_out(dis), .send_stall_hs_out(shs), .send_no_hs_out(nhs));
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [23:0] e);
        checks++;
        if ({st, irq, sf, dis, shs, nhs} !== e)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, {st, irq, sf, dis, shs, nhs}, e);
        end
    endtask : cmp
    task automatic cmp_rdy(input logic [P-1:0] e);
        checks++;
        if (brq !== e)
        begin
            failures++;
            $display("ERROR %0t ready got %h expected %h", $time, brq, e);
        end
    endtask : cmp_rdy
    // monitor: one note per result cycle, looked at mid-cycle where outputs are settled
    always @(negedge ref_clk_in)
    begin
        if (chk) cmp(q.pop_front());
        if (chr) cmp_rdy(qr.pop_front());
    end
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            failures++;
            complete_run();
        end
    end
    // edge takes the event, next cycle is compared
    task automatic go(input logic [P-1:0] nf, s, input logic d, h, n);
        qr.push_back(rq);
        rq = '0;
        chr = 1'b1;
        @(posedge ref_clk_in);
        #1 i_ube_peer_model.idle();
        chr = 1'b0;
        sw = 1'b0;
        q.push_back({nf, |(nf & en), s, d, h, n});
        fl = nf;
        chk = 1'b1;
        @(posedge ref_clk_in);
        #1 chk = 1'b0;
    endtask : go
    task automatic tx(input int g, input logic e, c, a, b, set);
        {emp, cw, ac, bc} = {{P{e}}, {P{c}}, {P{a}}, {P{b}}};
        i_ube_peer_model.send_tx(g);
        rq = (g != UBE_CTRL_PIPE && !DB[g]) ? P'(set) << g : '0;
        go(fl | (P'(set) << g), '0, 1'b0, 1'b0, 1'b0);
    endtask : tx
    task automatic rx(input int g, input logic o, c, s, p, set);
        i_ube_peer_model.send_rx(g, o ? M + 11'($urandom_range(1, 40)) : 11'($urandom_range(0, 64)), c, s, p);
        go(fl | (P'(set) << g), P'(set) << g, set, set & fm, set & !fm);
    endtask : rx
    task automatic clr(input logic [P-1:0] w);
        sw = 1'b1;
        wd = w;
        go(fl & w, '0, 1'b0, 1'b0, 1'b0);
    endtask : clr
    initial
    begin
        void'($urandom(32'h8A97));
        repeat (6) @(posedge ref_clk_in);
        #1 srst_in = 1'b0;
        tx(1, 1, 0, 0, 0, 1);
        tx(3, 0, 0, 0, 0, 0);
        tx(2, 1, 1, 0, 0, 0);
        tx(2, 1, 0, 0, 0, 1);
        tx(4, 1, 0, 1, 0, 0);
        tx(4, 1, 0, 0, 1, 0);
        fm = 1'b1;
        ss = 1'b1;
        tx(0, 1, 0, 0, 0, 0);
        ss = 1'b0;
        tx(0, 1, 0, 0, 0, 1);
        rx(5, 1, 0, 0, 0, 1);
        fm = 1'b0;
        rx(6, 1, 0, 0, 0, 1);
        rx(7, 1, 1, 0, 0, 0);
        rx(7, 1, 0, 1, 0, 0);
        rx(7, 1, 0, 0, 1, 0);
        rx(8, 0, 0, 0, 0, 0);
        rx(9, 1, 0, 0, 0, 0);
        clr(~10'h002);
        clr(P'($urandom));
        tx(4, 1, 0, 0, 0, 1);
        clr(10'h010);
        go(fl, '0, 1'b0, 1'b0, 1'b0);
        en = '1;
        go(fl, '0, 1'b0, 1'b0, 1'b0);
        clr('0);
        go(fl, '0, 1'b0, 1'b0, 1'b0);
        complete_run();
    end
endmodule : tb
`default_nettype wire

// file: verification/ube_buffer_empty_irq_asserts.sv
// port-level assertions for the buffer-empty interrupt block
`timescale 1ns/100ps
`default_nettype none
module ube_chk
    import ube_pkg::*;
#(parameter int PIPES = UBE_PIPES, parameter int MPS_W = UBE_MPS_W)
(
    // clock, reset and stimulus seen by the block
    input wire logic ref_clk_in, srst_in, func_mode_in, rx_done_in, sts_wr_in,
    input wire logic rx_crc_err_in, rx_stuff_err_in, setup_in,
    input wire logic [3:0] rx_pipe_in,
    input wire logic [PIPES-1:0] pipe_dir_tx_in, dbl_buf_in, tx_done_in, auto_clear_mode_in,
    input wire logic [PIPES-1:0] fifo_clear_bit_in, sts_wdata_in, empty_enable_register_in,
    // results driven by the block
    input wire logic [PIPES-1:0] empty_status_register_out, buffer_ready_req_out, stall_force_out,
    input wire logic buffer_empty_interrupt_out, rx_discard_out, send_stall_hs_out, send_no_hs_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    a_flag_clear_zero:
        assert property ($past(srst_in) || (($past(empty_status_register_out) & ~empty_status_register_out
            & ~({PIPES{$past(sts_wr_in)}} & ~$past(sts_wdata_in))) == '0)) else $error("flag fell without zero write");
    a_flag_has_cause:
        assert property (!$past(srst_in) |-> (empty_status_register_out & ~$past(empty_status_register_out)
            & ~$past(tx_done_in | ({PIPES{rx_done_in}} & PIPES'(1 << rx_pipe_in)))) == '0) else $error("flag without event");
    a_no_sw_clear:
        assert property ((empty_status_register_out & ~$past(empty_status_register_out) & $past(tx_done_in
            & pipe_dir_tx_in & (auto_clear_mode_in | fifo_clear_bit_in))) == '0) else $error("flag on buffer clear");
    a_summary_follows:
        assert property (!$past(srst_in) |-> buffer_empty_interrupt_out
            == |(empty_status_register_out & $past(empty_enable_register_in))) else $error("summary wrong");
    a_discard_clean_rx:
        assert property (rx_discard_out |-> $past(rx_done_in && !rx_crc_err_in && !rx_stuff_err_in && !setup_in))
            else $error("discard without clean packet");
    a_handshake_mode:
        assert property (rx_discard_out |-> send_stall_hs_out == $past(func_mode_in)
            && send_no_hs_out != $past(func_mode_in)) else $error("handshake wrong for mode");
    a_stall_with_flag:
        assert property (|stall_force_out |-> rx_discard_out && $onehot(stall_force_out)
            && (stall_force_out & ~empty_status_register_out) == '0) else $error("stall without flag");
    a_ready_single:
        assert property ((buffer_ready_req_out & ~(tx_done_in & ~dbl_buf_in)) == '0
            && !buffer_ready_req_out[UBE_CTRL_PIPE]) else $error("ready request wrong");
endmodule : ube_chk
bind ube_buffer_empty_irq ube_chk #(.PIPES(PIPES), .MPS_W(MPS_W)) i_ube_chk (.*);
`default_nettype wire

// file: verification/ube_peer_model.sv
// behavioural usb peer delivering transmit and receive completions
`timescale 1ns/100ps
`default_nettype none
module ube_peer_model
    import ube_pkg::*;
#(parameter int PIPES = UBE_PIPES)
(
    // completion events towards the block
    output logic [PIPES-1:0]     tx_done_out,
    output logic                 rx_done_out, crc_err_out, stuff_err_out, setup_out,
    output logic [3:0]           rx_pipe_out,
    output logic [UBE_MPS_W-1:0] rx_len_out
);
    initial
    begin
        {rx_pipe_out, rx_len_out} = '0;
        idle();
    end
    // end of one transmission, zero length included
    task automatic send_tx(input int g);
        tx_done_out[g] = 1'b1;
    endtask : send_tx
    // one received packet with its qualifiers
    task automatic send_rx(input int g, input logic [UBE_MPS_W-1:0] n, input logic c, s, p);
        {rx_done_out, rx_pipe_out, rx_len_out, crc_err_out, stuff_err_out, setup_out} = {1'b1, 4'(g), n, c, s, p};
    endtask : send_rx
    // released length shows the inverse of the last value
    task automatic idle();
        {tx_done_out, rx_done_out, crc_err_out, stuff_err_out, setup_out} = '0;
        rx_len_out = ~rx_len_out;
    endtask : idle
endmodule : ube_peer_model
`default_nettype wire
